/* tb/ravr_top_bench.sv */
// Self-checking bench for the alarm value registers.
// Assumes the design sources and ravr_defs.svh are compiled before it.
`timescale 1ns/10ps
`include "ravr_defs.svh"
module ravr_top_bench;
	import ravr_pkg::*;
	logic ref_clk_in = 1'b0;
	logic rst_in = 1'b1;
	ravr_wb_req_t req = '0;
	ravr_wb_rsp_t rsp;
	ravr_cal_t now = '0;
	logic tick = 1'b0;
	logic match;
	logic irq;
	int err_total = 0;
	int checked = 0;
	int hits;
	logic [31:0] q, tv, dv;
	always #50 ref_clk_in = ~ref_clk_in;
	ravr_top dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.wb_req_in(req), .wb_rsp_out(rsp), .now_in(now),
		.sec_tick_in(tick), .alarm_match_out(match), .irq_out(irq));
////////////////////////////////////////////////////////////////////////////
	task complete_run;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Holds the request until ack is sampled, then releases it
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] rd);
		int n;
		@(posedge ref_clk_in);
		req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: s, adr: a, dat: d};
		n = 0;
		do begin
			@(posedge ref_clk_in);
			n++;
		end while (rsp.ack !== 1'b1 && n < 50);
		rd = rsp.dat;
		req <= '0;
		if (rsp.ack !== 1'b1) begin
			err_total++;
			complete_run();
		end
	endtask : wb
	task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0, 4'hf, q);
		chk(nm, e, q);
	endtask : rd_chk
	// Counts match pulses in a short window after one second tick
	task pulse_sec(output int h);
		h = 0;
		@(posedge ref_clk_in);
		tick <= 1'b1;
		@(posedge ref_clk_in);
		tick <= 1'b0;
		repeat (5) begin
			@(posedge ref_clk_in);
			h += (match === 1'b1);
		end
	endtask : pulse_sec
	function automatic ravr_cal_t cal(input logic [31:0] t,
		input logic [31:0] d);
		return '{t[29:28], t[27:24], t[22:20], t[19:16], t[14:12],
			t[11:8], d[20], d[19:16], d[13:12], d[11:8], d[2:0]};
	endfunction : cal
	task irq_chk(input logic e);
		repeat (3) @(posedge ref_clk_in);
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask : irq_chk
////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hee39cf71));
		repeat (3) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		rd_chk("time", `RAVR_OFF_TIME, 32'h0);
		rd_chk("date", `RAVR_OFF_DATE, 32'h0);
		rd_chk("status", `RAVR_OFF_STAT, 32'h0);
		irq_chk(1'b0);
		$display("test reset done");
		// All ones first, so every unimplemented bit is tried at once
		for (int i = 0; i < 12; i++) begin
			tv = (i == 0) ? 32'hffffffff : $urandom;
			dv = (i == 0) ? 32'hffffffff : $urandom;
			wb(1'b1, `RAVR_OFF_TIME, tv, 4'hf, q);
			wb(1'b1, `RAVR_OFF_DATE, dv, 4'hf, q);
			rd_chk("time", `RAVR_OFF_TIME, tv & 32'h3f7f7f00);
			rd_chk("date", `RAVR_OFF_DATE, dv & 32'h001f3f07);
		end
		wb(1'b1, `RAVR_OFF_TIME, 32'h0, 4'b0100, q);
		rd_chk("lane", `RAVR_OFF_TIME, tv & 32'h3f007f00);
		wb(1'b1, 8'h10, 32'hffffffff, 4'hf, q);
		rd_chk("unmapped", 8'h10, 32'h0);
		rd_chk("time", `RAVR_OFF_TIME, tv & 32'h3f007f00);
		$display("test fields done");
		// Largest calendar value in every field: 23:59:59, month 12, day 31, weekday 6
		tv = 32'h23595900;
		dv = 32'h00123106;
		wb(1'b1, `RAVR_OFF_STAT, 32'h3, 4'hf, q);
		wb(1'b1, `RAVR_OFF_TIME, tv, 4'hf, q);
		wb(1'b1, `RAVR_OFF_DATE, dv, 4'hf, q);
		rd_chk("status", `RAVR_OFF_STAT, 32'h0);
		now <= cal(tv ^ 32'h00000100, dv);
		pulse_sec(hits);
		chk("no match", 32'h0, hits);
		now <= cal(tv, dv ^ 32'h00000001);
		pulse_sec(hits);
		chk("weekday off", 32'h0, hits);
		now <= cal(tv, dv);
		pulse_sec(hits);
		chk("match", 32'h1, hits);
		rd_chk("status", `RAVR_OFF_STAT, 32'h1);
		irq_chk(1'b0);
		wb(1'b1, `RAVR_OFF_MASK, 32'h1, 4'hf, q);
		irq_chk(1'b1);
		wb(1'b1, `RAVR_OFF_STAT, 32'h1, 4'hf, q);
		rd_chk("status", `RAVR_OFF_STAT, 32'h0);
		irq_chk(1'b0);
		$display("test alarm done");
		// Hour tens of 3 is outside its range but still stored
		wb(1'b1, `RAVR_OFF_TIME, 32'h3a000000, 4'hf, q);
		rd_chk("time", `RAVR_OFF_TIME, 32'h3a000000);
		rd_chk("status", `RAVR_OFF_STAT, 32'h2);
		irq_chk(1'b0);
		wb(1'b1, `RAVR_OFF_MASK, 32'h3, 4'hf, q);
		irq_chk(1'b1);
		wb(1'b1, `RAVR_OFF_STAT, 32'h2, 4'hf, q);
		irq_chk(1'b0);
		// Month units of 10 and weekday 7 are kept but flagged
		wb(1'b1, `RAVR_OFF_DATE, 32'h001a0007, 4'hf, q);
		rd_chk("date", `RAVR_OFF_DATE, 32'h001a0007);
		rd_chk("status", `RAVR_OFF_STAT, 32'h2);
		irq_chk(1'b1);
		$display("test range done");
		complete_run();
	end
endmodule : ravr_top_bench

/* verilog/ravr_cmp.sv */
// Compares alarm fields with the running calendar on a second tick.
// Assumes now_in is stable when tick_in pulses.
`timescale 1ns/10ps
`include "ravr_defs.svh"
module ravr_cmp
	import ravr_pkg::*;
(
	input wire logic ref_clk_in, // Clock
	input wire logic rst_in, // Sync reset
	input wire ravr_pkg::ravr_cal_t alarm_in, // Alarm fields
	input wire ravr_pkg::ravr_cal_t now_in, // Running calendar
	input wire logic tick_in, // One-second pulse
	output logic match_out // Match pulse
);
	import ravr_pkg::*;
	logic match_r;
	always_ff @(posedge ref_clk_in) begin
		if (rst_in)
			match_r <= 1'b0;
		else
			match_r <= tick_in && (alarm_in == now_in);
	end
	assign match_out = match_r;
endmodule : ravr_cmp

/* verilog/ravr_defs.svh */
// Offsets, field positions, masks, reset values and status bits of the alarm value block.
// Assumes inclusion by bare name from ravr_top, ravr_cmp and the bench.
`ifndef RAVR_DEFS_SVH
`define RAVR_DEFS_SVH
`define RAVR_OFF_TIME 8'h00
`define RAVR_OFF_DATE 8'h04
`define RAVR_OFF_STAT 8'h08
`define RAVR_OFF_MASK 8'h0c
`define RAVR_TIME_MASK 32'h3f7f7f00
`define RAVR_DATE_MASK 32'h001f3f07
`define RAVR_HRT_LSB 28
`define RAVR_HRU_LSB 24
`define RAVR_MNT_LSB 20
`define RAVR_MNU_LSB 16
`define RAVR_SCT_LSB 12
`define RAVR_SCU_LSB 8
`define RAVR_MOT_LSB 20
`define RAVR_MOU_LSB 16
`define RAVR_DYT_LSB 12
`define RAVR_DYU_LSB 8
`define RAVR_WD_LSB 0
`define RAVR_TIME_RST 32'h00000000
`define RAVR_DATE_RST 32'h00000000
`define RAVR_IRQ_MATCH 0
`define RAVR_IRQ_WRERR 1
`endif

/* verilog/ravr_merge.sv */
// Byte-lane write merge with implemented-bit masking.
// Assumes sel is a classic Wishbone byte select.
`timescale 1ns/10ps
module ravr_merge #(
	parameter int WIDTH = 32
) (
	input wire logic [WIDTH-1:0] old_in, // Current value
	input wire logic [WIDTH-1:0] wdat_in, // Write data
	input wire logic [WIDTH/8-1:0] sel_in, // Byte select
	input wire logic [WIDTH-1:0] impl_in, // Implemented bits
	output logic [WIDTH-1:0] new_out // Merged value
);
	// Lanes are whole bytes; any other width cannot be byte-selected
	if (WIDTH < 8 || WIDTH % 8 != 0) begin : g_bad_width
		$error("ravr_merge: width not whole bytes");
	end
	genvar g;
	for (g = 0; g < WIDTH / 8; g++) begin : g_lane
		assign new_out[g*8 +: 8] = sel_in[g] ?
			(wdat_in[g*8 +: 8] & impl_in[g*8 +: 8]) : old_in[g*8 +: 8];
	end
endmodule : ravr_merge

/* verilog/ravr_pkg.sv */
// Types shared by the alarm value block.
// Assumes ravr_defs.svh is on the include path.
package ravr_pkg;
	typedef struct packed {
		logic [1:0] hour_tens;
		logic [3:0] hour_units;
		logic [2:0] minute_tens;
		logic [3:0] minute_units;
		logic [2:0] second_tens;
		logic [3:0] second_units;
		logic month_tens;
		logic [3:0] month_units;
		logic [1:0] mday_tens;
		logic [3:0] mday_units;
		logic [2:0] weekday;
	} ravr_cal_t;
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [7:0] adr;
		logic [31:0] dat;
	} ravr_wb_req_t;
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} ravr_wb_rsp_t;
	typedef enum logic [1:0] {
		RAVR_IDLE,
		RAVR_ACK
	} ravr_bus_state_t;
endpackage : ravr_pkg

/* verilog/ravr_top.sv */
// Alarm time and date value registers on a classic Wishbone slave.
// Assumes a synchronous bus master on ref_clk_in and a running calendar.
//
// Functional notes
// - hour tens, bits 29-28, 0 to 2
// - hour units, bits 27-24, 0 to 9
// - minute tens, bits 22-20, 0 to 5
// - minute units, bits 19-16
// - second tens, bits 14-12
// - second units, bits 11-8
// - time unused bits read zero
// - month tens, bit 20, 0 or 1
// - month units, bits 19-16
// - day tens, bits 13-12, 0 to 3
// - day units, bits 11-8
// - weekday, bits 2-0, 0 to 6
// - date unused bits read zero
//
// Decided for this implementation: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps
`include "ravr_defs.svh"
module ravr_top
	import ravr_pkg::*;
(
	input wire logic ref_clk_in, // 10 MHz clock
	input wire logic rst_in, // Sync reset, high
	input wire ravr_pkg::ravr_wb_req_t wb_req_in, // Wishbone request
	output ravr_pkg::ravr_wb_rsp_t wb_rsp_out, // Wishbone answer
	input wire ravr_pkg::ravr_cal_t now_in, // Running calendar
	input wire logic sec_tick_in, // One-second pulse
	output logic alarm_match_out, // Match pulse
	output logic irq_out // Level interrupt
);
	import ravr_pkg::*;

	////////////////////////////////////////////////////////////////////
	typedef struct packed {
		ravr_bus_state_t st;
		logic ack;
		logic [31:0] rdat;
		logic [31:0] time_v;
		logic [31:0] date_v;
		logic [1:0] stat;
		logic [1:0] mask;
		logic match;
		logic irq;
	} ravr_state_t;

	ravr_state_t s_r;
	ravr_state_t s_nxt;
	ravr_cal_t alarm_c;
	logic [31:0] time_new;
	logic [31:0] date_new;
	logic cmp_match;

	function automatic logic legal_time(input logic [31:0] v);
		legal_time = v[29:28] <= 2'h2 && v[27:24] <= 4'h9 &&
			v[22:20] <= 3'h5 && v[19:16] <= 4'h9 &&
			v[14:12] <= 3'h5 && v[11:8] <= 4'h9;
	endfunction : legal_time

	function automatic logic legal_date(input logic [31:0] v);
		legal_date = v[19:16] <= 4'h9 && v[13:12] <= 2'h3 &&
			v[11:8] <= 4'h9 && v[2:0] <= 3'h6;
	endfunction : legal_date

	////////////////////////////////////////////////////////////////////
	// Field extraction from the stored words
	always_comb begin
		alarm_c.hour_tens = s_r.time_v[`RAVR_HRT_LSB +: 2];
		alarm_c.hour_units = s_r.time_v[`RAVR_HRU_LSB +: 4];
		alarm_c.minute_tens = s_r.time_v[`RAVR_MNT_LSB +: 3];
		alarm_c.minute_units = s_r.time_v[`RAVR_MNU_LSB +: 4];
		alarm_c.second_tens = s_r.time_v[`RAVR_SCT_LSB +: 3];
		alarm_c.second_units = s_r.time_v[`RAVR_SCU_LSB +: 4];
		alarm_c.month_tens = s_r.date_v[`RAVR_MOT_LSB];
		alarm_c.month_units = s_r.date_v[`RAVR_MOU_LSB +: 4];
		alarm_c.mday_tens = s_r.date_v[`RAVR_DYT_LSB +: 2];
		alarm_c.mday_units = s_r.date_v[`RAVR_DYU_LSB +: 4];
		alarm_c.weekday = s_r.date_v[`RAVR_WD_LSB +: 3];
	end

	ravr_merge #(.WIDTH(32)) u_mtime (
		.old_in(s_r.time_v),
		.wdat_in(wb_req_in.dat),
		.sel_in(wb_req_in.sel),
		.impl_in(`RAVR_TIME_MASK),
		.new_out(time_new)
	);

	ravr_merge #(.WIDTH(32)) u_mdate (
		.old_in(s_r.date_v),
		.wdat_in(wb_req_in.dat),
		.sel_in(wb_req_in.sel),
		.impl_in(`RAVR_DATE_MASK),
		.new_out(date_new)
	);

	ravr_cmp u_cmp (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.alarm_in(alarm_c),
		.now_in(now_in),
		.tick_in(sec_tick_in),
		.match_out(cmp_match)
	);

	////////////////////////////////////////////////////////////////////
	// Bus slave, registers, interrupt status
	always_comb begin
		logic req;
		logic [1:0] ev;
		logic [1:0] clr;
		req = 1'b0;
		ev = 2'b00;
		clr = 2'b00;
		s_nxt = s_r;
		s_nxt.ack = 1'b0;
		req = wb_req_in.cyc && wb_req_in.stb;
		case (s_r.st)
			RAVR_IDLE: begin
				if (req) begin
					s_nxt.ack = 1'b1;
					s_nxt.st = RAVR_ACK;
					s_nxt.rdat = 32'h00000000;
					case (wb_req_in.adr)
						`RAVR_OFF_TIME: s_nxt.rdat = s_r.time_v;
						`RAVR_OFF_DATE: s_nxt.rdat = s_r.date_v;
						`RAVR_OFF_STAT: s_nxt.rdat = {30'h0, s_r.stat};
						`RAVR_OFF_MASK: s_nxt.rdat = {30'h0, s_r.mask};
						default: s_nxt.rdat = 32'h00000000;
					endcase
					if (wb_req_in.we) begin
						case (wb_req_in.adr)
							`RAVR_OFF_TIME: begin
								s_nxt.time_v = time_new;
								ev[`RAVR_IRQ_WRERR] = !legal_time(time_new);
							end
							`RAVR_OFF_DATE: begin
								s_nxt.date_v = date_new;
								ev[`RAVR_IRQ_WRERR] = !legal_date(date_new);
							end
							`RAVR_OFF_STAT: begin
								if (wb_req_in.sel[0])
									clr = wb_req_in.dat[1:0];
							end
							`RAVR_OFF_MASK: begin
								if (wb_req_in.sel[0])
									s_nxt.mask = wb_req_in.dat[1:0];
							end
							default: ;
						endcase
					end
				end
			end
			RAVR_ACK: s_nxt.st = RAVR_IDLE;
			default: s_nxt.st = RAVR_IDLE;
		endcase
		ev[`RAVR_IRQ_MATCH] = cmp_match;
		// Set beats clear so an event in the clear cycle is kept
		s_nxt.stat = (s_r.stat & ~clr) | ev;
		s_nxt.match = cmp_match;
		s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			s_r.st <= RAVR_IDLE;
			s_r.ack <= 1'b0;
			s_r.rdat <= 32'h00000000;
			s_r.time_v <= `RAVR_TIME_RST;
			s_r.date_v <= `RAVR_DATE_RST;
			s_r.stat <= 2'h0;
			s_r.mask <= 2'h0;
			s_r.match <= 1'b0;
			s_r.irq <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign wb_rsp_out.ack = s_r.ack;
	assign wb_rsp_out.dat = s_r.rdat;
	assign alarm_match_out = s_r.match;
	assign irq_out = s_r.irq;

	////////////////////////////////////////////////////////////////////
	// Assertions
	property p_time_zero;
		@(posedge ref_clk_in) disable iff (rst_in)
		(s_r.time_v & ~`RAVR_TIME_MASK) == 32'h0;
	endproperty
	a_time_zero: assert property (p_time_zero)
		else $error("time unused bits not zero");

	property p_date_zero;
		@(posedge ref_clk_in) disable iff (rst_in)
		(s_r.date_v & ~`RAVR_DATE_MASK) == 32'h0;
	endproperty
	a_date_zero: assert property (p_date_zero)
		else $error("date unused bits not zero");

	property p_hour_wr;
		@(posedge ref_clk_in) disable iff (rst_in)
		(s_r.st == RAVR_IDLE && wb_req_in.cyc && wb_req_in.stb &&
			wb_req_in.we && wb_req_in.adr == `RAVR_OFF_TIME &&
			wb_req_in.sel[3])
		|=> s_r.time_v[29:24] == $past(wb_req_in.dat[29:24]);
	endproperty
	a_hour_wr: assert property (p_hour_wr)
		else $error("hour field not stored");

	property p_sec_wr;
		@(posedge ref_clk_in) disable iff (rst_in)
		(s_r.st == RAVR_IDLE && wb_req_in.cyc && wb_req_in.stb &&
			wb_req_in.we && wb_req_in.adr == `RAVR_OFF_TIME &&
			wb_req_in.sel[1])
		|=> s_r.time_v[14:8] == $past(wb_req_in.dat[14:8]);
	endproperty
	a_sec_wr: assert property (p_sec_wr)
		else $error("second field not stored");

	property p_wday_rd;
		@(posedge ref_clk_in) disable iff (rst_in)
		(s_r.st == RAVR_IDLE && wb_req_in.cyc && wb_req_in.stb &&
			!wb_req_in.we && wb_req_in.adr == `RAVR_OFF_DATE)
		|=> wb_rsp_out.ack && wb_rsp_out.dat[2:0] == $past(s_r.date_v[2:0]);
	endproperty
	a_wday_rd: assert property (p_wday_rd)
		else $error("weekday read wrong");

	property p_ack_once;
		@(posedge ref_clk_in) disable iff (rst_in)
		wb_rsp_out.ack |=> !wb_rsp_out.ack;
	endproperty
	a_ack_once: assert property (p_ack_once)
		else $error("ack longer than one cycle");

	property p_match;
		@(posedge ref_clk_in) disable iff (rst_in)
		(sec_tick_in && alarm_c == now_in) |-> ##2 alarm_match_out;
	endproperty
	a_match: assert property (p_match)
		else $error("alarm match missed");

	property p_no_match;
		@(posedge ref_clk_in) disable iff (rst_in)
		!sec_tick_in |-> ##2 !alarm_match_out;
	endproperty
	a_no_match: assert property (p_no_match)
		else $error("match without tick");

	property p_irq;
		@(posedge ref_clk_in) disable iff (rst_in)
		irq_out == |(s_r.stat & s_r.mask);
	endproperty
	a_irq: assert property (p_irq)
		else $error("irq not following status");

	property p_min_wr;
		@(posedge ref_clk_in) disable iff (rst_in)
		(s_r.st == RAVR_IDLE && wb_req_in.cyc && wb_req_in.stb &&
			wb_req_in.we && wb_req_in.adr == `RAVR_OFF_TIME &&
			wb_req_in.sel[2])
		|=> s_r.time_v[22:16] == $past(wb_req_in.dat[22:16]);
	endproperty
	a_min_wr: assert property (p_min_wr)
		else $error("minute field not stored");

	property p_month_wr;
		@(posedge ref_clk_in) disable iff (rst_in)
		(s_r.st == RAVR_IDLE && wb_req_in.cyc && wb_req_in.stb &&
			wb_req_in.we && wb_req_in.adr == `RAVR_OFF_DATE &&
			wb_req_in.sel[2])
		|=> s_r.date_v[20:16] == $past(wb_req_in.dat[20:16]);
	endproperty
	a_month_wr: assert property (p_month_wr)
		else $error("month field not stored");

	property p_mday_wr;
		@(posedge ref_clk_in) disable iff (rst_in)
		(s_r.st == RAVR_IDLE && wb_req_in.cyc && wb_req_in.stb &&
			wb_req_in.we && wb_req_in.adr == `RAVR_OFF_DATE &&
			wb_req_in.sel[1])
		|=> s_r.date_v[13:8] == $past(wb_req_in.dat[13:8]);
	endproperty
	a_mday_wr: assert property (p_mday_wr)
		else $error("day of month field not stored");

	property p_wday_wr;
		@(posedge ref_clk_in) disable iff (rst_in)
		(s_r.st == RAVR_IDLE && wb_req_in.cyc && wb_req_in.stb &&
			wb_req_in.we && wb_req_in.adr == `RAVR_OFF_DATE &&
			wb_req_in.sel[0])
		|=> s_r.date_v[2:0] == $past(wb_req_in.dat[2:0]);
	endproperty
	a_wday_wr: assert property (p_wday_wr)
		else $error("weekday field not stored");

	// Only a taken write may move the stored alarm time
	property p_time_keep;
		@(posedge ref_clk_in) disable iff (rst_in)
		!(s_r.st == RAVR_IDLE && wb_req_in.cyc && wb_req_in.stb &&
			wb_req_in.we && wb_req_in.adr == `RAVR_OFF_TIME)
		|=> $stable(s_r.time_v);
	endproperty
	a_time_keep: assert property (p_time_keep)
		else $error("time changed without a write");

	property p_date_keep;
		@(posedge ref_clk_in) disable iff (rst_in)
		!(s_r.st == RAVR_IDLE && wb_req_in.cyc && wb_req_in.stb &&
			wb_req_in.we && wb_req_in.adr == `RAVR_OFF_DATE)
		|=> $stable(s_r.date_v);
	endproperty
	a_date_keep: assert property (p_date_keep)
		else $error("date changed without a write");

	// A time write with out-of-range digits must be flagged in status
	property p_range_err;
		@(posedge ref_clk_in) disable iff (rst_in)
		(s_r.st == RAVR_IDLE && wb_req_in.cyc && wb_req_in.stb &&
			wb_req_in.we && wb_req_in.adr == `RAVR_OFF_TIME &&
			!legal_time(time_new))
		|=> s_r.stat[`RAVR_IRQ_WRERR];
	endproperty
	a_range_err: assert property (p_range_err)
		else $error("range error not flagged");
endmodule : ravr_top
